/* File: pkg/ftsr_pkg.sv */
package ftsr_pkg;
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int DATA_W = LANES * BYTE_W;
    localparam int WORD_W = DATA_W + LANES;
    localparam int DEPTH = 262144;
    localparam int BURST_W = 2;
    // Burst order strap encoding
    localparam logic MODE_LINEAR = 1'h0;
    localparam logic MODE_INTERLEAVED = 1'h1;
    // Reset values of control state
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam logic SCAN_RST = 1'h0;
endpackage : ftsr_pkg

/* File: verilog/ftsr_core.sv */
`timescale 1ns/1ns
// What this block does
// - Output enable low and no mask: drive data and parity lanes.
// - Output enable high: all data and parity lanes float as inputs.
// - Float during write data cycle, first cycle after deselect, and while deselected.
// - Act on a rising edge only when clock qualifier is sampled low.
// - Clock qualifier high: access logic and array ignore the edge, keep their state.
// - High qualifier stretches the previous cycle, never deselects.
// - Sleep input high: enter sleep, stored contents kept intact.
// - Write data on the lanes is captured at the rising clock edge.
// - Read drives data of address registered at the preceding edge.
// - Parity lanes act like data; written only with their byte select.
// - Burst strap low: burst counter steps linearly.
// - Burst strap high or open: interleaved burst sequence.
// - Scan serial output changes on falling test clock edge.
// - Scan serial input sampled on rising test clock edge.
// - Advance high steps burst counter; low loads a new address.
// - Selected only with select 1 and 3 low and select 2 high.
module ftsr_core (
    input wire logic sys_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic [ftsr_pkg::ADDR_W-1:0] addr, // Address
    input wire logic chip_select_1_n, // Select 1
    input wire logic chip_select_2, // Select 2
    input wire logic chip_select_3_n, // Select 3
    input wire logic write_n, // Write strobe
    input wire logic advance_or_load, // Advance high, load low
    input wire logic [ftsr_pkg::LANES-1:0] byte_write_select_n, // Byte selects
    input wire logic clock_qualify_n, // Clock qualifier
    input wire logic output_enable_n, // Output enable, synchronised through two flops
    input wire logic sleep_request, // Sleep input
    input wire logic burst_mode, // Burst order strap
    input wire logic [ftsr_pkg::DATA_W-1:0] data_in, // Data lanes in
    output logic [ftsr_pkg::DATA_W-1:0] data_out, // Data lanes out
    output logic data_oe, // Data lanes drive
    input wire logic [ftsr_pkg::LANES-1:0] parity_in, // Parity lanes in
    output logic [ftsr_pkg::LANES-1:0] parity_out, // Parity lanes out
    output logic parity_oe, // Parity lanes drive
    input wire logic test_clk, // Scan clock pin
    input wire logic scan_in, // Scan serial in
    output logic scan_out // Scan serial out
);
    ////////////////////////////////////////////////////////////////////////
    logic [ftsr_pkg::WORD_W-1:0] mem [ftsr_pkg::DEPTH];
    logic oe_m, oe_s, zz_m, zz_s, md_m, md_s, tck_m, tck_s, tck_d, tdi_m, tdi_s;
    logic mode;
    logic active, wr_op, emerge;
    logic [ftsr_pkg::ADDR_W-1:0] base;
    logic [ftsr_pkg::BURST_W-1:0] cnt;
    logic [ftsr_pkg::LANES-1:0] bw;
    logic [ftsr_pkg::WORD_W-1:0] rd_word;
    logic scan_reg;
    logic run, selected, load;
    logic [ftsr_pkg::BURST_W-1:0] next_cnt;
    logic [ftsr_pkg::ADDR_W-1:0] cur_addr, next_addr;
    logic [ftsr_pkg::WORD_W-1:0] in_word, next_word;
    logic commit;

    function automatic logic [ftsr_pkg::BURST_W-1:0] burst_low(
        input logic [ftsr_pkg::BURST_W-1:0] start,
        input logic [ftsr_pkg::BURST_W-1:0] step,
        input logic m
    );
        if (m == ftsr_pkg::MODE_LINEAR) begin
            burst_low = start + step;
        end else begin
            burst_low = start ^ step;
        end
    endfunction : burst_low

    ////////////////////////////////////////////////////////////////////////
    // Pins from outside the clock domain pass two flops
    always_ff @(posedge sys_clk) begin
        oe_m <= output_enable_n;
        oe_s <= oe_m;
        zz_m <= sleep_request;
        zz_s <= zz_m;
        md_m <= burst_mode;
        md_s <= md_m;
        tck_m <= test_clk;
        tck_s <= tck_m;
        tck_d <= tck_s;
        tdi_m <= scan_in;
        tdi_s <= tdi_m;
    end

    // Strap is caught while reset is held, then frozen
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode <= md_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep freezes the access logic like a masked edge, so array and state survive
    assign run = !clock_qualify_n && !zz_s;
    assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
    assign load = !advance_or_load;
    assign cur_addr = {base[ftsr_pkg::ADDR_W-1:ftsr_pkg::BURST_W],
        burst_low(base[ftsr_pkg::BURST_W-1:0], cnt, mode)};
    assign next_cnt = load ? ftsr_pkg::CNT_RST : cnt + 2'h1;
    assign next_addr = load ? addr : {base[ftsr_pkg::ADDR_W-1:ftsr_pkg::BURST_W],
        burst_low(base[ftsr_pkg::BURST_W-1:0], next_cnt, mode)};
    assign commit = run && active && wr_op;

    // Access control; a masked edge leaves it all untouched
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            active <= 1'b0;
            wr_op <= 1'b0;
            emerge <= 1'b0;
            cnt <= ftsr_pkg::CNT_RST;
            base <= '0;
            bw <= '1;
        end else if (run) begin
            emerge <= load && selected && !active;
            bw <= byte_write_select_n;
            cnt <= next_cnt;
            if (load) begin
                active <= selected;
                wr_op <= !write_n;
                base <= addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    generate
        for (genvar i = 0; i < ftsr_pkg::LANES; i++) begin : g_lane
            assign in_word[i*ftsr_pkg::BYTE_W +: ftsr_pkg::BYTE_W] =
                data_in[i*ftsr_pkg::BYTE_W +: ftsr_pkg::BYTE_W];
            assign in_word[ftsr_pkg::DATA_W+i] = parity_in[i];
            // Parity bit follows its own byte select
            assign next_word[i*ftsr_pkg::BYTE_W +: ftsr_pkg::BYTE_W] = bw[i] ?
                mem[cur_addr][i*ftsr_pkg::BYTE_W +: ftsr_pkg::BYTE_W] :
                in_word[i*ftsr_pkg::BYTE_W +: ftsr_pkg::BYTE_W];
            assign next_word[ftsr_pkg::DATA_W+i] = bw[i] ?
                mem[cur_addr][ftsr_pkg::DATA_W+i] : in_word[ftsr_pkg::DATA_W+i];
        end
    endgenerate

    // Write data lands one edge after its address
    always_ff @(posedge sys_clk) begin
        if (commit) begin
            mem[cur_addr] <= next_word;
        end
    end

    // Read word is taken with the address, bypassed over a same-edge write
    always_ff @(posedge sys_clk) begin
        if (run) begin
            if (commit && next_addr == cur_addr) begin
                rd_word <= next_word;
            end else begin
                rd_word <= mem[next_addr];
            end
        end
    end

    assign data_out = rd_word[ftsr_pkg::DATA_W-1:0];
    assign parity_out = rd_word[ftsr_pkg::WORD_W-1:ftsr_pkg::DATA_W];
    assign data_oe = !oe_s && active && !wr_op && !emerge && !zz_s;
    assign parity_oe = data_oe;

    ////////////////////////////////////////////////////////////////////////
    // Scan: one-bit path, input on test clock rise, output on its fall
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scan_reg <= ftsr_pkg::SCAN_RST;
            scan_out <= ftsr_pkg::SCAN_RST;
        end else begin
            if (tck_s && !tck_d) begin
                scan_reg <= tdi_s;
            end
            if (!tck_s && tck_d) begin
                scan_out <= scan_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_masked_edge;
        clock_qualify_n || zz_s;
    endsequence

    sequence s_write_load;
        run && load && selected && !write_n;
    endsequence

    // A read load while already selected, so no emerge mask follows
    sequence s_live_read_load;
        run && load && selected && write_n && active;
    endsequence

    sequence s_tck_fall;
        !tck_s && tck_d;
    endsequence

    AST_DRIVE: assert property (@(posedge sys_clk) disable iff (srst)
        s_live_read_load ##1 (!oe_s && !zz_s) |-> (data_oe && parity_oe))
        else $error("lanes not driven on enabled read");
    AST_OE_FLOAT: assert property (@(posedge sys_clk) disable iff (srst)
        oe_s |-> !data_oe && !parity_oe)
        else $error("lanes driven with output enable high");
    AST_WRITE_FLOAT: assert property (@(posedge sys_clk) disable iff (srst)
        s_write_load |=> !data_oe && !parity_oe)
        else $error("lanes driven in write data cycle");
    AST_DESEL_FLOAT: assert property (@(posedge sys_clk) disable iff (srst)
        (run && load && selected && !active) |=> !data_oe)
        else $error("lanes driven on first cycle after deselect");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
        s_masked_edge |=> $stable(active) && $stable(cnt) && $stable(base) && $stable(wr_op))
        else $error("state changed on a masked edge");
    AST_LOAD: assert property (@(posedge sys_clk) disable iff (srst)
        (run && load && selected) |=> active && base == $past(addr) && cnt == 2'h0
            && wr_op == !$past(write_n))
        else $error("selected load not captured");
    AST_DESELECT: assert property (@(posedge sys_clk) disable iff (srst)
        (run && load && !selected) |=> !active ##0 !data_oe)
        else $error("deselect not taken");
    AST_ADVANCE: assert property (@(posedge sys_clk) disable iff (srst)
        (run && !load) |=> cnt == $past(cnt) + 2'h1 && $stable(active))
        else $error("burst counter did not advance");
    AST_SCAN_OUT: assert property (@(posedge sys_clk) disable iff (srst)
        $changed(scan_out) |-> $past(!tck_s && tck_d))
        else $error("scan output moved off a falling test clock");
    AST_SCAN_FALL: assert property (@(posedge sys_clk) disable iff (srst)
        s_tck_fall |=> scan_out == $past(scan_reg))
        else $error("scan output not updated on falling test clock");
endmodule : ftsr_core

/* File: verification/ftsr_ctl_model.sv */
`timescale 1ns/1ns
// Lane resolver for the controller side; released lanes toggle so stale data never passes
module ftsr_ctl_model (
    input wire logic sys_clk, // System clock
    input wire logic drive_en, // Controller drives lanes
    input wire logic [ftsr_pkg::WORD_W-1:0] drive_word, // Parity and data driven
    input wire logic dev_oe, // Device drives lanes
    input wire logic [ftsr_pkg::WORD_W-1:0] dev_word, // Device parity and data
    output logic [ftsr_pkg::WORD_W-1:0] lane // Resolved lanes
);
    logic [ftsr_pkg::WORD_W-1:0] last = '0;
    always_comb lane = dev_oe ? dev_word : (drive_en ? drive_word : ~last);
    always @(posedge sys_clk) last <= lane;
endmodule : ftsr_ctl_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic sys_clk = 1'h0, srst = 1'h1, wn = 1'h1, adv = 1'h0, cqn = 1'h0, oen = 1'h0;
    logic zz = 1'h0, mode = 1'h0, tck = 1'h0, tdi = 1'h0, ctl_en = 1'h0;
    logic [2:0] cs = 3'h7;
    logic [17:0] addr = 18'h0;
    logic [35:0] ctl_d = 36'h0;
    logic [31:0] dout;
    logic [3:0] pout;
    logic [3:0] bws = 4'h0;
    logic doe, poe, tdo;
    wire logic [35:0] lane;
    int mismatches = 0, check_count = 0;
    ftsr_core uut (.sys_clk(sys_clk), .srst(srst), .addr(addr), .chip_select_1_n(cs[2]),
        .chip_select_2(cs[1]), .chip_select_3_n(cs[0]), .write_n(wn), .advance_or_load(adv),
        .byte_write_select_n(bws), .clock_qualify_n(cqn), .output_enable_n(oen),
        .sleep_request(zz), .burst_mode(mode), .data_in(lane[31:0]), .data_out(dout),
        .data_oe(doe), .parity_in(lane[35:32]), .parity_out(pout), .parity_oe(poe),
        .test_clk(tck), .scan_in(tdi), .scan_out(tdo));
    ftsr_ctl_model ctl (.sys_clk(sys_clk), .drive_en(ctl_en), .drive_word(ctl_d),
        .dev_oe(doe), .dev_word({pout, dout}), .lane(lane));
    initial forever #4 sys_clk = ~sys_clk;
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // Select pattern 3'b010 selects, write strobe, advance, address
    task automatic cmd(input logic [2:0] s, input logic w, input logic v, input logic [17:0] a);
        @(posedge sys_clk);
        cs <= s; wn <= !w; adv <= v; addr <= a;
    endtask : cmd
    // Strap is only taken while reset is held
    task automatic reset_dut(input logic m);
        @(posedge sys_clk);
        mode <= m;
        srst <= 1'h1;
        cs <= 3'h7;
        repeat (5) @(posedge sys_clk);
        srst <= 1'h0;
    endtask : reset_dut
    task automatic write_read();
        cmd(3'h2, 1, 0, 18'h100);
        cmd(3'h2, 0, 0, 18'h100);
        ctl_en <= 1'h1;
        ctl_d <= 36'hA11223344;
        #1 chk(36'(doe), 0);
        cmd(3'h7, 0, 0, 18'h0);
        ctl_en <= 1'h0;
        cqn <= 1'h1;
        #1 chk({pout, dout}, 36'hA11223344);
        chk(36'(doe), 1);
        chk(36'(poe), 1);
        cmd(3'h7, 0, 0, 18'h0);
        cqn <= 1'h0;
        #1 chk({pout, dout}, 36'hA11223344);
        chk(36'(doe), 1);
        cmd(3'h7, 0, 0, 18'h0);
        #1 chk(36'(doe), 0);
        chk(36'(poe), 0);
    endtask : write_read
    // Lanes 1 and 3 masked: their bytes and parity bits must survive
    task automatic byte_write();
        cmd(3'h2, 1, 0, 18'h100);
        bws <= 4'hA;
        cmd(3'h7, 0, 0, 18'h0);
        bws <= 4'h0;
        ctl_en <= 1'h1;
        ctl_d <= 36'h555667788;
        cmd(3'h2, 0, 0, 18'h100);
        ctl_en <= 1'h0;
        cmd(3'h2, 0, 0, 18'h100);
        #1 chk({pout, dout}, 36'hF11663388);
        cmd(3'h2, 0, 0, 18'h100);
        #1 chk(36'(poe), 1);
    endtask : byte_write
    task automatic select_decode();
        for (int p = 0; p < 8; p++) begin
            cmd(3'(p), 0, 0, 18'h100);
            cmd(3'(p), 0, 0, 18'h100);
            cmd(3'h7, 0, 0, 18'h0);
            #1 chk(36'(doe), 36'(p == 2));
        end
    endtask : select_decode
    task automatic burst_order(input logic m);
        cmd(3'h2, 1, 0, 18'h201);
        for (int k = 0; k < 4; k++) begin
            cmd(3'h7, 0, k < 3, 18'h0);
            ctl_en <= 1'h1;
            ctl_d <= 36'hA0 + 36'(k);
        end
        cmd(3'h2, 0, 0, 18'h203);
        ctl_en <= 1'h0;
        for (int j = 0; j < 5; j++) begin
            cmd(j < 4 ? 3'h2 : 3'h7, 0, 0, 18'h200 + 18'(j));
            #1;
            if (j > 0) begin
                chk({pout, dout}, 36'hA0 + 36'(m ? (j - 1) ^ 1 : (j + 2) % 4));
                chk(36'(doe), 1);
            end
        end
    endtask : burst_order
    task automatic oe_float();
        cmd(3'h2, 0, 0, 18'h200);
        oen <= 1'h1;
        repeat (3) cmd(3'h2, 0, 0, 18'h200);
        #1 chk(36'(doe), 0);
        chk(36'(poe), 0);
        cmd(3'h2, 0, 0, 18'h200);
        oen <= 1'h0;
    endtask : oe_float
    task automatic sleep_hold(input logic m);
        cmd(3'h2, 0, 0, 18'h200);
        zz <= 1'h1;
        repeat (3) cmd(3'h2, 0, 0, 18'h200);
        #1 chk(36'(doe), 0);
        cmd(3'h2, 0, 0, 18'h200);
        zz <= 1'h0;
        repeat (5) cmd(3'h2, 0, 0, 18'h200);
        #1 chk({pout, dout}, 36'hA0 + 36'(m ? 1 : 3));
        chk(36'(doe), 1);
    endtask : sleep_hold
    // Scan path resynchronises the test clock, so allow several system cycles
    task automatic scan_edges();
        @(posedge sys_clk);
        tdi <= 1'h1;
        tck <= 1'h1;
        repeat (5) @(posedge sys_clk);
        #1 chk(36'(tdo), 0);
        @(posedge sys_clk);
        tck <= 1'h0;
        repeat (5) @(posedge sys_clk);
        #1 chk(36'(tdo), 1);
        @(posedge sys_clk);
        tdi <= 1'h0;
    endtask : scan_edges
    task automatic run(input logic m);
        reset_dut(m);
        write_read();
        byte_write();
        select_decode();
        burst_order(m);
        oe_float();
        sleep_hold(m);
        scan_edges();
    endtask : run
    initial begin
        run(1'h0);
        run(1'h1);
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule : tb_top
